// ===== rtl/dpa_regs.svh
// Offsets, field positions, codes and reset values of the drive access block
// Summary of operation
// RULE1 - Tasks in by write service, answers out
// RULE2 - One exchange may address several parameters
// RULE3 - Deactivated parameter answers error code 0x65
// RULE4 - Unassigned signal parameter read gives 0x65
// RULE5 - Master may read each parameter's description
// RULE6 - Block number is parameter, word is subindex
// RULE7 - Source 4 fieldbus, source 0 terminals
// RULE8 - Panel never writes setpoints directly
// RULE9 - Panel link loss raises no fault
// RULE10 - Fieldbus boot at commissioning clears input functions
// RULE11 - Reuse select 1 makes output two input
// RULE12 - Terminal beats fieldbus signal for inputs
// RULE13 - Status shown on terminal and status word
// RULE14 - Inhibit with switch bit 12 blocks start
// RULE15 - Switch bit 13 resets to one
// RULE16 - Bits 13 and 14 mask rising-edge inhibit
// RULE17 - Master clears inhibit by dropping on/off
// RULE18 - Switch bit 12 zero disables inhibit
// RULE19 - Inhibit latched and shown in status word
`ifndef DPA_REGS_SVH
`define DPA_REGS_SVH

// ----------------------------------------
// Avalon register byte offsets
// ----------------------------------------
`define DPA_OFS_STATUS   5'h00
`define DPA_OFS_IRQ_STAT 5'h04
`define DPA_OFS_IRQ_MASK 5'h08
`define DPA_OFS_MOTOR    5'h0C
`define DPA_OFS_PARAMS   5'h10

// ----------------------------------------
// Parameter numbers and signal range
// ----------------------------------------
`define DPA_P_SRC    16'h036B
`define DPA_P_REUSE  16'h02A5
`define DPA_P_FN0    16'h0294
`define DPA_P_FN1    16'h0295
`define DPA_P_FN2    16'h0296
`define DPA_P_FSW    16'h03F4
`define DPA_P_FIXSP  16'h0281
`define DPA_P_IND    16'h043B
`define DPA_P_SPASG  16'h0393
`define DPA_P_ACASG  16'h0394
`define DPA_SIG_LO   16'hC350
`define DPA_SIG_HI   16'hC737
`define DPA_SIG_CW   16'hC351

// ----------------------------------------
// Error codes and parameter values
// ----------------------------------------
`define DPA_ERR_NOPAR 8'h00
`define DPA_ERR_RO    8'h01
`define DPA_ERR_RANGE 8'h02
`define DPA_ERR_DEACT 8'h65
`define DPA_SRC_TERM  8'h00
`define DPA_SRC_FB    8'h04
`define DPA_REUSE_ON  8'h01
`define DPA_FN_MAX    8'h03
`define DPA_FN0_RST   8'h01
`define DPA_FN1_RST   8'h02
`define DPA_FN2_RST   8'h03

// ----------------------------------------
// Function switch, status word and interrupt bits
// ----------------------------------------
`define DPA_FS_EN      12
`define DPA_FS_PROF    13
`define DPA_FS_RELAX   14
`define DPA_FS_RST     16'h3000
`define DPA_SW_READY   0
`define DPA_SW_RUN     1
`define DPA_SW_INHIBIT 6
`define DPA_SW_PANEL   7
`define DPA_IRQ_DONE   0
`define DPA_IRQ_ERR    1
`define DPA_IRQ_INHON  2
`define DPA_IRQ_INHOFF 3

`endif

// ===== rtl/dpa_pkg.sv
// Types of the drive access block
package dpa_pkg;
  typedef enum logic [1:0] {KIND_READ, KIND_WRITE, KIND_DESC} dpa_kind_t;
  typedef enum logic {SRC_CLASS1, SRC_PANEL} dpa_src_t;
  typedef enum logic {ST_IDLE, ST_RESP} dpa_fsm_t;

  typedef struct packed {
    dpa_kind_t   kind;
    dpa_src_t    src;
    logic [15:0] pnum;
    logic [7:0]  sub;
    logic [31:0] value;
    logic        last;
  } dpa_task_t;

  typedef struct packed {
    logic        err;
    logic [7:0]  code;
    logic [31:0] value;
    logic        last;
  } dpa_resp_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [31:0] writedata;
  } dpa_av_req_t;

  typedef struct packed {
    dpa_fsm_t         fsm;
    dpa_resp_t        resp;
    logic [4:0]       sync1;
    logic [4:0]       sync2;
    logic [1:0]       settle;
    logic             boot_done;
    logic [7:0]       src_sel;
    logic [7:0]       reuse;
    logic [2:0][7:0]  in_fn;
    logic [15:0]      fs;
    logic [31:0]      fixed_sp;
    logic [15:0]      ind_par;
    logic [3:0][15:0] sp_asg;
    logic [3:0][15:0] ac_asg;
    logic             motor_ind;
    logic             inhibit;
    logic [2:0]       eff_prev;
    logic [15:0]      status_word;
    logic [31:0]      setpoint;
    logic [3:0]       irq_stat;
    logic [3:0]       irq_mask;
    logic             av_served;
    logic [31:0]      av_rdata;
  } dpa_state_t;
endpackage

// ===== rtl/dpa_top.sv
// Drive parameter access, control source and power-on inhibit logic
//
// The register offsets and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`include "dpa_regs.svh"
module dpa_top (
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  // Avalon-MM slave
  input  wire dpa_pkg::dpa_av_req_t i_av,
  output logic [31:0]               o_av_readdata,
  output logic                      o_av_waitrequest,
  output logic                      o_irq,
  // Acyclic task stream and answers
  input  wire dpa_pkg::dpa_task_t   i_task,
  input  wire logic                 i_task_valid,
  output logic                      o_task_ready,
  output dpa_pkg::dpa_resp_t        o_resp,
  output logic                      o_resp_valid,
  input  wire logic                 i_resp_ready,
  // Cyclic process data from class 1 master
  input  wire logic [15:0]          i_cw,
  input  wire logic [31:0]          i_fb_setpoint,
  output logic [15:0]               o_status_word,
  output logic [31:0]               o_setpoint,
  // Drive state
  input  wire logic                 i_drive_fault,
  input  wire logic                 i_panel_link_ok,
  // Pins
  input  wire logic                 i_term0,
  input  wire logic                 i_term1,
  input  wire logic                 i_dout2,
  output logic                      o_dout2,
  output logic                      o_dout2_oe,
  output logic                      o_dout1,
  input  wire logic                 i_boot_fb,
  input  wire logic                 i_first_comm
);
  import dpa_pkg::*;

  dpa_state_t q;
  dpa_state_t d;

  // ----------------------------------------
  // Terminal to function mapping
  // ----------------------------------------
  logic [2:0] t_en;
  logic [2:0] t_lvl;
  logic [2:0] has_term;
  logic [2:0] term_val;
  logic [2:0] eff;
  logic       reuse_on;

  assign reuse_on = (q.reuse == `DPA_REUSE_ON);

  genvar gt;
  genvar gf;
  generate
    for (gt = 0; gt < 3; gt++) begin : g_term
      assign t_en[gt]  = (gt != 2) || reuse_on; // RULE11
      assign t_lvl[gt] = q.sync2[gt];
    end
    for (gf = 0; gf < 3; gf++) begin : g_func
      logic [2:0] m;
      for (gt = 0; gt < 3; gt++) begin : g_hit
        assign m[gt] = t_en[gt] && (q.in_fn[gt] == 8'(gf + 1));
      end
      assign has_term[gf] = |m;
      assign term_val[gf] = |(m & t_lvl);
    end
  endgenerate

  // Terminal first, fieldbus only as class 1 source
  always_comb begin
    for (int f = 0; f < 3; f++) begin
      if (has_term[f]) begin
        eff[f] = term_val[f]; // RULE12
      end else if (q.src_sel == `DPA_SRC_FB) begin
        eff[f] = i_cw[f]; // RULE7
      end else begin
        eff[f] = (f != 0);
      end
    end
  end

  // ----------------------------------------
  // Parameter lookup
  // ----------------------------------------
  logic [3:0]  asg_hit;
  logic        p_ex;
  logic        p_wr;
  logic        p_deact;
  logic        p_arr;
  logic        p_bad;
  logic [31:0] p_rv;
  logic        p_sig;

  generate
    for (gt = 0; gt < 4; gt++) begin : g_asg
      assign asg_hit[gt] = (q.sp_asg[gt] == i_task.pnum)
                        || (q.ac_asg[gt] == i_task.pnum);
    end
  endgenerate

  assign p_sig = (i_task.pnum >= `DPA_SIG_LO) && (i_task.pnum <= `DPA_SIG_HI);

  // Block number and word number decode the same way for every source
  always_comb begin
    p_ex    = 1'b1; // RULE6
    p_wr    = 1'b1;
    p_deact = 1'b0;
    p_arr   = 1'b0;
    p_bad   = 1'b0;
    p_rv    = 32'h0000_0000;
    case (i_task.pnum)
      `DPA_P_SRC: begin
        p_rv  = {24'h000000, q.src_sel};
        p_bad = (i_task.value[7:0] != `DPA_SRC_FB)
             && (i_task.value[7:0] != `DPA_SRC_TERM);
      end
      `DPA_P_REUSE: begin
        p_rv  = {24'h000000, q.reuse};
        p_bad = i_task.value[7:1] != 7'h00;
      end
      `DPA_P_FN0, `DPA_P_FN1, `DPA_P_FN2: begin
        p_rv  = {24'h000000, q.in_fn[i_task.pnum[1:0] - 2'h0]};
        p_bad = i_task.value[7:0] > `DPA_FN_MAX;
      end
      `DPA_P_FSW: begin
        p_rv = {16'h0000, q.fs};
      end
      `DPA_P_FIXSP: begin
        p_rv = q.fixed_sp;
      end
      `DPA_P_IND: begin
        p_rv    = {16'h0000, q.ind_par};
        p_deact = !q.motor_ind; // RULE3
      end
      `DPA_P_SPASG, `DPA_P_ACASG: begin
        p_arr = 1'b1;
        p_ex  = i_task.sub[7:2] == 6'h00;
        p_rv  = {16'h0000, i_task.pnum[0] ? q.ac_asg[i_task.sub[1:0]]
                                          : q.sp_asg[i_task.sub[1:0]]};
      end
      default: begin
        p_ex    = p_sig;
        p_wr    = 1'b0;
        p_deact = !(|asg_hit); // RULE4
        p_rv    = (i_task.pnum == `DPA_SIG_CW) ? {16'h0000, i_cw}
                                               : {16'h0000, q.status_word};
      end
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic        av_req;
  logic        av_take;
  logic        av_wr;
  logic        take;
  logic        set_cond;
  logic        run;
  logic [3:0]  ev;
  logic [3:0]  clr;
  logic [15:0] sw;
  dpa_resp_t   r;

  assign av_req  = i_av.read || i_av.write;
  assign av_take = av_req && !q.av_served;
  assign av_wr   = q.av_served && i_av.write;
  assign take    = (q.fsm == ST_IDLE) && i_task_valid;

  always_comb begin
    d   = q;
    ev  = 4'h0;
    clr = 4'h0;
    sw  = 16'h0000;
    r   = '0;

    // Pin synchronisers
    d.sync1 = {i_first_comm, i_boot_fb, i_dout2, i_term1, i_term0};
    d.sync2 = q.sync1;

    // Commissioning preset once pins have settled
    if (!q.boot_done) begin
      d.settle = q.settle + 2'h1;
      if (q.settle == 2'h3) begin
        d.boot_done = 1'b1;
        if (q.sync2[4] && q.sync2[3]) begin
          d.in_fn = '0; // RULE10
        end
      end
    end

    // Task handling, one answer for each element of an exchange
    case (q.fsm)
      ST_IDLE: begin
        if (take) begin
          r.last  = i_task.last; // RULE2
          r.value = p_rv;
          if (!p_ex) begin
            r.err  = 1'b1;
            r.code = `DPA_ERR_NOPAR;
          end else if (i_task.kind == KIND_DESC) begin
            r.value = {29'h0, p_arr, p_wr, 1'b1}; // RULE5
          end else if (p_deact) begin
            r.err  = 1'b1;
            r.code = `DPA_ERR_DEACT; // RULE3 RULE4
          end else if (i_task.kind == KIND_WRITE && !p_wr) begin
            r.err  = 1'b1;
            r.code = `DPA_ERR_RO;
          end else if (i_task.kind == KIND_WRITE && p_bad) begin
            r.err  = 1'b1;
            r.code = `DPA_ERR_RANGE;
          end else if (i_task.kind == KIND_WRITE) begin
            r.value = i_task.value;
            // Tasks change setpoints only through stored parameters
            case (i_task.pnum) // RULE8
              `DPA_P_SRC:   d.src_sel = i_task.value[7:0];
              `DPA_P_REUSE: d.reuse = i_task.value[7:0];
              `DPA_P_FN0:   d.in_fn[0] = i_task.value[7:0];
              `DPA_P_FN1:   d.in_fn[1] = i_task.value[7:0];
              `DPA_P_FN2:   d.in_fn[2] = i_task.value[7:0];
              `DPA_P_FSW:   d.fs = i_task.value[15:0];
              `DPA_P_FIXSP: d.fixed_sp = i_task.value;
              `DPA_P_IND:   d.ind_par = i_task.value[15:0];
              `DPA_P_SPASG: d.sp_asg[i_task.sub[1:0]] = i_task.value[15:0];
              `DPA_P_ACASG: d.ac_asg[i_task.sub[1:0]] = i_task.value[15:0];
              default:      d.fs = q.fs;
            endcase
          end
          d.resp = r; // RULE1
          d.fsm  = ST_RESP;
          ev[`DPA_IRQ_DONE] = 1'b1;
          ev[`DPA_IRQ_ERR]  = r.err;
        end
      end
      ST_RESP: begin
        if (i_resp_ready) begin
          d.fsm = ST_IDLE;
        end
      end
      default: d.fsm = ST_IDLE;
    endcase

    // Power-on inhibit
    set_cond = !eff[1] || !eff[2]
            || (q.fs[`DPA_FS_PROF] && !q.fs[`DPA_FS_RELAX]
                && |(eff & ~q.eff_prev)); // RULE16
    d.eff_prev = eff;
    if (!q.fs[`DPA_FS_EN]) begin
      d.inhibit = 1'b0; // RULE18
    end else if (set_cond) begin
      d.inhibit = 1'b1; // RULE19
    end else if (!eff[0]) begin
      d.inhibit = 1'b0; // RULE17
    end
    ev[`DPA_IRQ_INHON]  = d.inhibit && !q.inhibit;
    ev[`DPA_IRQ_INHOFF] = !d.inhibit && q.inhibit;

    // Run only with all enables and no inhibit
    // Held low as well in the cycle that raises the inhibit
    run = (eff == 3'h7) && !q.inhibit && !(q.fs[`DPA_FS_EN] && set_cond)
        && !i_drive_fault; // RULE14
    sw[`DPA_SW_READY]   = !i_drive_fault && !q.inhibit;
    sw[`DPA_SW_RUN]     = run;
    sw[`DPA_SW_INHIBIT] = q.inhibit; // RULE19
    sw[`DPA_SW_PANEL]   = i_panel_link_ok; // RULE9
    d.status_word = sw;
    d.setpoint = (q.src_sel == `DPA_SRC_FB) ? i_fb_setpoint : q.fixed_sp; // RULE7

    // Register bus
    d.av_served = av_take;
    if (av_take) begin
      case (i_av.address)
        `DPA_OFS_STATUS:   d.av_rdata = {16'h0000, q.status_word};
        `DPA_OFS_IRQ_STAT: d.av_rdata = {28'h0000000, q.irq_stat};
        `DPA_OFS_IRQ_MASK: d.av_rdata = {28'h0000000, q.irq_mask};
        `DPA_OFS_MOTOR:    d.av_rdata = {31'h00000000, q.motor_ind};
        `DPA_OFS_PARAMS:   d.av_rdata = {q.src_sel, q.reuse, q.fs};
        default:           d.av_rdata = 32'h0000_0000;
      endcase
    end
    if (av_wr) begin
      case (i_av.address)
        `DPA_OFS_IRQ_STAT: clr = i_av.writedata[3:0];
        `DPA_OFS_IRQ_MASK: d.irq_mask = i_av.writedata[3:0];
        `DPA_OFS_MOTOR:    d.motor_ind = i_av.writedata[0];
        default:           d.irq_mask = q.irq_mask;
      endcase
    end
    // Set wins over clear
    d.irq_stat = (q.irq_stat & ~clr) | ev;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q          <= '0;
      q.fsm      <= ST_IDLE;
      q.fs       <= `DPA_FS_RST; // RULE15
      q.inhibit  <= 1'b1;
      q.in_fn[0] <= `DPA_FN0_RST;
      q.in_fn[1] <= `DPA_FN1_RST;
      q.in_fn[2] <= `DPA_FN2_RST;
      q.src_sel  <= `DPA_SRC_FB;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_av_waitrequest = av_req && !q.av_served;
  assign o_av_readdata    = q.av_rdata;
  assign o_irq            = |(q.irq_stat & q.irq_mask);
  assign o_task_ready     = (q.fsm == ST_IDLE);
  assign o_resp           = q.resp;
  assign o_resp_valid     = (q.fsm == ST_RESP);
  assign o_status_word    = q.status_word;
  assign o_setpoint       = q.setpoint;
  assign o_dout1          = q.status_word[`DPA_SW_RUN]; // RULE13
  assign o_dout2          = q.status_word[`DPA_SW_INHIBIT]; // RULE13
  assign o_dout2_oe       = !reuse_on; // RULE11

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_accept;
    (q.fsm == ST_IDLE) && i_task_valid;
  endsequence

  sequence s_ind_read;
    s_accept ##0 (i_task.kind == KIND_READ) && (i_task.pnum == `DPA_P_IND)
      && !q.motor_ind;
  endsequence

  a_resp_follows: assert property (s_accept |=> o_resp_valid && !o_task_ready) // RULE1
    else $error("answer did not follow accepted task");
  a_elem_last: assert property (s_accept |=> o_resp.last == $past(i_task.last)) // RULE2
    else $error("answer last flag does not match element");
  a_deact_code: assert property (s_ind_read |=> o_resp.err && o_resp.code == 8'h65) // RULE3
    else $error("deactivated parameter not refused with 0x65");
  a_sig_refuse: assert property (s_accept ##0 i_task.kind == KIND_READ && p_sig
      && !(|asg_hit) |=> o_resp.err && o_resp.code == 8'h65) // RULE4
    else $error("unassigned signal read not refused");
  a_src_fb: assert property (q.src_sel == 8'h04 && !i_rst // RULE7
      |=> o_setpoint == $past(i_fb_setpoint))
    else $error("fieldbus setpoint not taken");
  a_src_fixed: assert property (q.src_sel == 8'h00 |=> o_setpoint == $past(q.fixed_sp)) // RULE8
    else $error("fixed setpoint not taken");
  a_term_prio: assert property (q.fs[12] && has_term[2] && !term_val[2] |=> q.inhibit) // RULE12
    else $error("terminal quick stop did not win");
  a_dual_out: assert property (!reuse_on |-> o_dout2_oe && o_dout2 == o_status_word[6]) // RULE13
    else $error("status terminal differs from status word");
  a_no_start: assert property (q.inhibit |=> !o_status_word[1] ##1 !o_dout1 || !q.inhibit) // RULE14
    else $error("drive ran while inhibited");
  a_relax_edge: assert property (q.fs[12] && q.fs[13] && q.fs[14] && eff == 3'h7
      && q.eff_prev == 3'h6 && !q.inhibit |=> !q.inhibit) // RULE16
    else $error("rising on/off set inhibit in relaxed mode");
  a_inh_off: assert property (!q.fs[12] |=> !q.inhibit) // RULE18
    else $error("inhibit active while disabled");
  a_inh_latch: assert property (q.inhibit && q.fs[12] && eff[0] |=> q.inhibit) // RULE19
    else $error("inhibit dropped without removal");
  a_av_answer: assert property (av_req && o_av_waitrequest |=> !o_av_waitrequest) // RULE1
    else $error("register access not answered in one cycle");
  a_boot_clear: assert property (!q.boot_done && q.settle == 2'h3 // RULE10
      && q.sync2[4] && q.sync2[3] |=> q.in_fn == '0)
    else $error("input functions not cleared at fieldbus boot");
  a_fault_stop: assert property (i_drive_fault |=> !o_status_word[1]) // RULE14
    else $error("drive ran with a fault present");
endmodule

// ===== verification/dpa_master_model.sv
// Fieldbus master or operator panel model that offers tasks and takes answers
`timescale 1ns/1ps
module dpa_master_model (
  // Clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  // Task stream toward the drive
  output dpa_pkg::dpa_task_t      o_task,
  output logic                    o_task_valid,
  input  wire logic               i_task_ready,
  // Answers from the drive
  input  wire dpa_pkg::dpa_resp_t i_resp,
  input  wire logic               i_resp_valid,
  output logic                    o_resp_ready
);
  import dpa_pkg::*;

  initial begin
    o_task       = '0;
    o_task_valid = 1'b0;
    o_resp_ready = 1'b0;
  end

  // One element out, its answer back after stall cycles of back-pressure
  task automatic xfer(input dpa_task_t t, input int stall, output dpa_resp_t r);
    @(posedge i_clk);
    o_task       <= t;
    o_task_valid <= 1'b1;
    do @(posedge i_clk); while (!i_task_ready);
    o_task       <= ~t;
    o_task_valid <= 1'b0;
    do @(posedge i_clk); while (!i_resp_valid);
    repeat (stall) @(posedge i_clk);
    o_resp_ready <= 1'b1;
    @(posedge i_clk);
    r = i_resp;
    o_resp_ready <= 1'b0;
  endtask
endmodule

// ===== verification/drive_param_access_and_inhibit_bench.sv
// Self-checking bench of the drive parameter access and inhibit block
`timescale 1ns/1ps
`include "dpa_regs.svh"
module drive_param_access_and_inhibit_bench;
  import dpa_pkg::*;
  logic        i_clk;
  logic        i_rst;
  dpa_av_req_t i_av;
  logic [31:0] o_av_readdata;
  logic        o_av_waitrequest;
  logic        o_irq;
  dpa_task_t   i_task;
  logic        i_task_valid;
  logic        o_task_ready;
  dpa_resp_t   o_resp;
  logic        o_resp_valid;
  logic        i_resp_ready;
  logic [15:0] i_cw;
  logic [31:0] i_fb_setpoint;
  logic [15:0] o_status_word;
  logic [31:0] o_setpoint;
  logic        i_drive_fault;
  logic        i_panel_link_ok;
  logic        i_term0;
  logic        i_term1;
  logic        i_dout2;
  logic        o_dout2;
  logic        o_dout2_oe;
  logic        o_dout1;
  logic        i_boot_fb;
  logic        i_first_comm;
  logic        pin2_ext;
  logic [31:0] rd;
  dpa_resp_t   rsp;
  int          stall_cyc;
  int          miscompares;
  int          n_checks;

  // Pin level of the shared output two terminal
  assign i_dout2 = o_dout2_oe ? o_dout2 : pin2_ext;

  dpa_top dut_u (
    .i_clk, .i_rst, .i_av, .o_av_readdata, .o_av_waitrequest, .o_irq,
    .i_task, .i_task_valid, .o_task_ready, .o_resp, .o_resp_valid, .i_resp_ready,
    .i_cw, .i_fb_setpoint, .o_status_word, .o_setpoint, .i_drive_fault,
    .i_panel_link_ok, .i_term0, .i_term1, .i_dout2, .o_dout2, .o_dout2_oe,
    .o_dout1, .i_boot_fb, .i_first_comm
  );

  dpa_master_model mst_u (
    .i_clk, .i_rst, .o_task(i_task), .o_task_valid(i_task_valid),
    .i_task_ready(o_task_ready), .i_resp(o_resp), .i_resp_valid(o_resp_valid),
    .o_resp_ready(i_resp_ready)
  );

  always #5 i_clk = ~i_clk;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic chk_rsp(input logic e, input logic [7:0] c, input logic [31:0] v);
    chk(rsp.err, e);
    if (e) chk(rsp.code, c);
    else chk(rsp.value, v);
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_av.read      <= !wr;
    i_av.write     <= wr;
    i_av.address   <= a;
    i_av.writedata <= d;
    do @(posedge i_clk); while (o_av_waitrequest);
    rd = o_av_readdata;
    i_av.read  <= 1'b0;
    i_av.write <= 1'b0;
    // Let the access settle before returning
    @(posedge i_clk);
  endtask

  task automatic pt(input dpa_kind_t k, input dpa_src_t s, input logic [15:0] p,
                    input logic [7:0] sb, input logic [31:0] v, input logic lst);
    dpa_task_t t;
    t = '{kind: k, src: s, pnum: p, sub: sb, value: v, last: lst};
    mst_u.xfer(t, stall_cyc, rsp);
  endtask

  task automatic do_reset;
    @(posedge i_clk);
    i_rst <= 1'b1;
    step(3);
    i_rst <= 1'b0;
    step(6);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_defaults;
    chk(o_status_word[`DPA_SW_INHIBIT], 1'b1);
    pt(KIND_READ, SRC_CLASS1, `DPA_P_FSW, 8'h00, 32'h0, 1'b1);
    chk_rsp(1'b0, 8'h00, {16'h0000, `DPA_FS_RST});
    pt(KIND_READ, SRC_PANEL, `DPA_P_SRC, 8'h00, 32'h0, 1'b1);
    chk_rsp(1'b0, 8'h00, {24'h0, `DPA_SRC_FB});
    av(1'b0, 5'h14, 32'h0);
    chk(rd, 32'h0);
  endtask

  task automatic t_source;
    pt(KIND_WRITE, SRC_PANEL, `DPA_P_SRC, 8'h00, 32'h0, 1'b1);
    chk_rsp(1'b0, 8'h00, 32'h0);
    pt(KIND_WRITE, SRC_PANEL, `DPA_P_FIXSP, 8'h00, 32'h000055AA, 1'b1);
    step(2);
    chk(o_setpoint, 32'h000055AA);
    pt(KIND_WRITE, SRC_CLASS1, `DPA_P_SRC, 8'h00, 32'h4, 1'b1);
    step(2);
    chk(o_setpoint, i_fb_setpoint);
    pt(KIND_WRITE, SRC_CLASS1, `DPA_P_SRC, 8'h00, 32'h2, 1'b1);
    chk_rsp(1'b1, `DPA_ERR_RANGE, 32'h0);
  endtask

  task automatic t_deact;
    av(1'b1, `DPA_OFS_MOTOR, 32'h0);
    pt(KIND_WRITE, SRC_CLASS1, `DPA_P_IND, 8'h00, 32'h1, 1'b1);
    chk_rsp(1'b1, `DPA_ERR_DEACT, 32'h0);
    pt(KIND_READ, SRC_PANEL, `DPA_P_IND, 8'h00, 32'h0, 1'b1);
    chk_rsp(1'b1, `DPA_ERR_DEACT, 32'h0);
    av(1'b1, `DPA_OFS_MOTOR, 32'h1);
    pt(KIND_READ, SRC_PANEL, `DPA_P_IND, 8'h00, 32'h0, 1'b1);
    chk(rsp.err, 1'b0);
  endtask

  task automatic t_signal;
    i_cw <= 16'h0A50;
    stall_cyc = 3;
    pt(KIND_READ, SRC_PANEL, `DPA_SIG_CW, 8'h00, 32'h0, 1'b1);
    chk_rsp(1'b1, `DPA_ERR_DEACT, 32'h0);
    pt(KIND_WRITE, SRC_CLASS1, `DPA_P_SPASG, 8'h01, {16'h0, `DPA_SIG_CW}, 1'b0);
    chk(rsp.last, 1'b0);
    pt(KIND_READ, SRC_CLASS1, `DPA_SIG_CW, 8'h00, 32'h0, 1'b1);
    chk(rsp.last, 1'b1);
    chk_rsp(1'b0, 8'h00, {16'h0, i_cw});
    pt(KIND_READ, SRC_CLASS1, `DPA_SIG_HI, 8'h00, 32'h0, 1'b1);
    chk_rsp(1'b1, `DPA_ERR_DEACT, 32'h0);
    pt(KIND_READ, SRC_PANEL, `DPA_P_SPASG, 8'h04, 32'h0, 1'b1);
    chk_rsp(1'b1, `DPA_ERR_NOPAR, 32'h0);
    stall_cyc = 0;
  endtask

  task automatic t_desc;
    pt(KIND_DESC, SRC_CLASS1, `DPA_P_FSW, 8'h00, 32'h0, 1'b1);
    chk(rsp.value[2:0], 3'h3);
    pt(KIND_DESC, SRC_PANEL, `DPA_P_SPASG, 8'h00, 32'h0, 1'b1);
    chk(rsp.value[2:0], 3'h7);
    pt(KIND_DESC, SRC_CLASS1, 16'h0001, 8'h00, 32'h0, 1'b1);
    chk_rsp(1'b1, `DPA_ERR_NOPAR, 32'h0);
  endtask

  task automatic t_terminals;
    pt(KIND_WRITE, SRC_CLASS1, `DPA_P_REUSE, 8'h00, 32'h1, 1'b1);
    pt(KIND_WRITE, SRC_CLASS1, `DPA_P_FSW, 8'h00, 32'h2000, 1'b1);
    step(2);
    chk(o_dout2_oe, 1'b0);
    pin2_ext <= 1'b1;
    i_term0  <= 1'b1;
    i_term1  <= 1'b1;
    i_cw     <= 16'h0001;
    step(6);
    chk(o_status_word[`DPA_SW_RUN], 1'b1);
    chk(o_dout1, 1'b1);
    i_term0 <= 1'b0;
    step(6);
    chk(o_status_word[`DPA_SW_RUN], 1'b0);
  endtask

  task automatic t_inhibit;
    for (int i = 0; i < 3; i++) begin
      pt(KIND_WRITE, SRC_CLASS1, `DPA_P_FN0 + 16'(i), 8'h00, 32'h0, 1'b1);
    end
    i_cw <= 16'h0006;
    pt(KIND_WRITE, SRC_CLASS1, `DPA_P_FSW, 8'h00, 32'h3000, 1'b1);
    av(1'b1, `DPA_OFS_IRQ_MASK, 32'h4);
    av(1'b1, `DPA_OFS_IRQ_STAT, 32'hF);
    chk(o_status_word[`DPA_SW_INHIBIT], 1'b0);
    chk(o_irq, 1'b0);
    i_cw <= 16'h0007;
    step(3);
    chk(o_status_word[`DPA_SW_INHIBIT], 1'b1);
    chk(o_dout2, 1'b1);
    chk(o_status_word[`DPA_SW_RUN], 1'b0);
    chk(o_irq, 1'b1);
    i_cw <= 16'h0006;
    step(3);
    chk(o_status_word[`DPA_SW_INHIBIT], 1'b0);
    av(1'b0, `DPA_OFS_IRQ_STAT, 32'h0);
    chk(rd, 32'hC);
    av(1'b1, `DPA_OFS_IRQ_STAT, 32'h4);
    chk(o_irq, 1'b0);
    pt(KIND_WRITE, SRC_CLASS1, `DPA_P_FSW, 8'h00, 32'h7000, 1'b1);
    i_cw <= 16'h0007;
    step(3);
    chk(o_status_word[`DPA_SW_INHIBIT], 1'b0);
    chk(o_status_word[`DPA_SW_RUN], 1'b1);
    i_cw <= 16'h0005;
    step(3);
    i_cw <= 16'h0007;
    step(3);
    chk(o_status_word[`DPA_SW_INHIBIT], 1'b1);
    pt(KIND_WRITE, SRC_CLASS1, `DPA_P_FSW, 8'h00, 32'h2000, 1'b1);
    step(2);
    chk(o_status_word[`DPA_SW_INHIBIT], 1'b0);
    i_panel_link_ok <= 1'b0;
    step(3);
    chk(o_status_word[`DPA_SW_PANEL], 1'b0);
    chk(o_status_word[`DPA_SW_RUN], 1'b1);
    i_drive_fault <= 1'b1;
    step(3);
    chk(o_status_word[`DPA_SW_RUN], 1'b0);
    i_drive_fault <= 1'b0;
  endtask

  task automatic t_boot;
    i_boot_fb    <= 1'b1;
    i_first_comm <= 1'b1;
    do_reset;
    for (int i = 0; i < 3; i++) begin
      pt(KIND_READ, SRC_CLASS1, `DPA_P_FN0 + 16'(i), 8'h00, 32'h0, 1'b1);
      chk_rsp(1'b0, 8'h00, 32'h0);
    end
  endtask

  initial begin
    i_clk           = 1'b0;
    i_rst           = 1'b1;
    i_av            = '0;
    i_resp_ready    = 1'b0;
    i_cw            = 16'h0000;
    i_fb_setpoint   = 32'h00001234;
    i_drive_fault   = 1'b0;
    i_panel_link_ok = 1'b1;
    i_term0         = 1'b0;
    i_term1         = 1'b0;
    pin2_ext        = 1'b0;
    i_boot_fb       = 1'b0;
    i_first_comm    = 1'b0;
    stall_cyc       = 0;
    miscompares     = 0;
    n_checks        = 0;
    do_reset;
    t_defaults;
    t_source;
    t_deact;
    t_signal;
    t_desc;
    t_terminals;
    t_inhibit;
    t_boot;
    stop_test;
  end

  // Watchdog well past the expected run length
  initial begin
    step(20000);
    miscompares++;
    stop_test;
  end
endmodule
